// ### rtl/dtsa_consts.vh
// Purpose: Shared constants for the tearing/scroll/access command slice
// Assumes: Included by bare name from the command core only; the tearing generator does not include it
// Notes: Offsets here are command codes on the host byte stream
`ifndef DTSA_CONSTS_VH
`define DTSA_CONSTS_VH
// ==========================================================
// Command codes
`define DTSA_CMD_SWRESET 8'h01
`define DTSA_CMD_SLPIN 8'h10
`define DTSA_CMD_SLPOUT 8'h11
`define DTSA_CMD_TEAR_OFF 8'h34
`define DTSA_CMD_TEAR_ON 8'h35
`define DTSA_CMD_ACCESS 8'h36
`define DTSA_CMD_SCROLL 8'h37
`define DTSA_CMD_IDLE_OFF 8'h38
`define DTSA_CMD_IDLE_ON 8'h39
// ==========================================================
// Field positions in the memory access control byte
`define DTSA_BIT_PAGE 7
`define DTSA_BIT_COL 6
`define DTSA_BIT_SWAP 5
`define DTSA_BIT_LINE 4
`define DTSA_BIT_BGR 3
`define DTSA_BIT_LATCH 2
`define DTSA_ACCESS_MASK 8'hFC
// ==========================================================
// Reset values
`define DTSA_ACCESS_RST 8'h00
`define DTSA_SCROLL_RST 16'h0000
`define DTSA_TEAR_MODE_RST 1'b0
// Panel geometry
`define DTSA_PANEL_LINES 16'h0140
`endif

// ### rtl/dtsa_tear_gen.v
// Purpose: Drive the tearing sync pin from panel blanking flags
// Assumes: Blanking flags are synchronous to core_clk
// Notes: Output is registered; line refresh order never reaches here
module dtsa_tear_gen
(
  input wire core_clk,
  input wire resetn,
  input wire tearEnable,
  input wire tearMode,
  input wire sleepIn,
  input wire vBlank,
  input wire hBlank,
  output reg tearSyncPin
);
  // ==========================================================
  // Pin timing
  // Mode 0 shows vertical blanking only, mode 1 adds horizontal
  always @(posedge core_clk)
  begin
    if (!resetn)
      tearSyncPin <= 1'b0;
    else if (!tearEnable || sleepIn)
      tearSyncPin <= 1'b0;
    else if (tearMode)
      tearSyncPin <= vBlank | hBlank;
    else
      tearSyncPin <= vBlank;
  end
endmodule

// ### rtl/dtsa_cmd_core.v
// Purpose: Command interpreter for tearing, access control, scroll, idle
// Assumes: Host write strobe and select arrive as async pins; sampled
// Notes: Strobe rising edge detected after two-flop synchronisers
//
// Functional notes
// - Command 35h plus one byte enables tearing output, mode from bit 0.
// - Mode 0: tearing output shows vertical blanking only.
// - Mode 1: tearing output shows vertical and horizontal blanking.
// - Line refresh order bit never alters tearing output timing.
// - Sleep-in with tearing enabled holds tearing pin low.
// - Tearing-enable while already enabled changes nothing.
// - Command 36h takes one byte; bits 7..2 used, 1..0 unused.
// - Bit 7 page order: 0 top-down, 1 bottom-up.
// - Bit 6 column order: 0 left-right, 1 right-left.
// - Bit 5 swaps page and column addressing when set.
// - Bit 4 panel refresh line order: 0 top-down, 1 bottom-up.
// - Bit 3 colour order: 0 RGB, 1 BGR.
// - Bit 2 latch order along line: 0 left-right, 1 right-left.
// - Command 37h then high byte then low byte of scroll pointer.
// - Scroll pointer line is shown right below top fixed area.
// - New scroll pointer takes effect only at next panel scan.
// - Command 38h leaves idle mode, full colour, normal frame rate.
// - Idle-exit while not idle changes nothing.
// - Idle mode shows eight colours from component MSBs.
`include "dtsa_consts.vh"
module dtsa_cmd_core
#(
  parameter DATA_W = 8,
  parameter PTR_W = 16
)
(
  input wire core_clk,
  input wire resetn,
  input wire writeStrobe,
  input wire dataCommandSelect,
  input wire [DATA_W-1:0] hostData,
  input wire vBlank,
  input wire hBlank,
  input wire frameStart,
  input wire [PTR_W-1:0] topFixedHeight,
  input wire [PTR_W-1:0] panelLine,
  input wire [17:0] pixelIn,
  output wire tearSyncPin,
  output reg pageOrderBit,
  output reg columnOrderBit,
  output reg pageColumnSwapBit,
  output reg lineRefreshOrderBit,
  output reg colourOrderBit,
  output reg latchOrderBit,
  output reg [PTR_W-1:0] scrollStartPointer,
  output reg [PTR_W-1:0] memLine,
  output reg idleMode,
  output reg sleepIn,
  output reg [17:0] pixelOut
);
  // ==========================================================
  // Parser states
  localparam ST_IDLE = 2'b00;
  localparam ST_TEAR = 2'b01;
  localparam ST_ACC = 2'b10;
  localparam ST_SCR = 2'b11;

  // Compare a command byte with one code; called again in each of several branches
  function isCmd;
    input [DATA_W-1:0] b;
    input [DATA_W-1:0] code;
    begin
      isCmd = (b == code);
    end
  endfunction

  reg wrSync1_r;
  reg wrSync2_r;
  reg wrSync3_r;
  reg dcSync1_r;
  reg dcSync2_r;
  reg [DATA_W-1:0] datSync1_r;
  reg [DATA_W-1:0] datSync2_r;
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg scrHigh_r;
  reg [DATA_W-1:0] scrHiByte_r;
  reg [PTR_W-1:0] scrPend_r;
  reg tearEnable_r;
  reg tearMode_r;
  reg [DATA_W-1:0] access_r;
  wire wrRise;
  wire isCmdByte;
  wire isParByte;
  wire softReset;
  wire [PTR_W-1:0] offsetLine;
  wire [PTR_W-1:0] wrapLine;

  // ==========================================================
  // Pin synchronisers; first stage feeds only the second
  always @(posedge core_clk)
  begin
    if (!resetn)
    begin
      wrSync1_r <= 1'b1;
      wrSync2_r <= 1'b1;
      wrSync3_r <= 1'b1;
      dcSync1_r <= 1'b0;
      dcSync2_r <= 1'b0;
      datSync1_r <= 8'h00;
      datSync2_r <= 8'h00;
    end
    else
    begin
      wrSync1_r <= writeStrobe;
      wrSync2_r <= wrSync1_r;
      wrSync3_r <= wrSync2_r;
      dcSync1_r <= dataCommandSelect;
      dcSync2_r <= dcSync1_r;
      datSync1_r <= hostData;
      datSync2_r <= datSync1_r;
    end
  end

  // Data and select are stable around the strobe, so same-depth sync works
  assign wrRise = wrSync2_r & ~wrSync3_r;
  assign isCmdByte = wrRise & ~dcSync2_r;
  assign isParByte = wrRise & dcSync2_r;
  assign softReset = isCmdByte & isCmd(datSync2_r, `DTSA_CMD_SWRESET);

  // ==========================================================
  // Parameter collection state
  always @*
  begin
    state_nxt = state_r;
    if (isCmdByte)
    begin
      if (isCmd(datSync2_r, `DTSA_CMD_TEAR_ON))
        state_nxt = ST_TEAR;
      else if (isCmd(datSync2_r, `DTSA_CMD_ACCESS))
        state_nxt = ST_ACC;
      else if (isCmd(datSync2_r, `DTSA_CMD_SCROLL))
        state_nxt = ST_SCR;
      else
        state_nxt = ST_IDLE;
    end
    else if (isParByte)
    begin
      case (state_r)
        ST_TEAR: state_nxt = ST_IDLE;
        ST_ACC: state_nxt = ST_IDLE;
        ST_SCR: state_nxt = scrHigh_r ? ST_IDLE : ST_SCR;
        default: state_nxt = ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Command effects
  // Extra parameter bytes with no open command are ignored
  always @(posedge core_clk)
  begin
    if (!resetn)
    begin
      state_r <= ST_IDLE;
      scrHigh_r <= 1'b0;
      scrHiByte_r <= 8'h00;
      scrPend_r <= `DTSA_SCROLL_RST;
      tearEnable_r <= 1'b0;
      tearMode_r <= `DTSA_TEAR_MODE_RST;
      access_r <= `DTSA_ACCESS_RST;
      idleMode <= 1'b0;
      sleepIn <= 1'b1;
    end
    else if (softReset)
    begin
      // Access byte survives a soft reset
      state_r <= ST_IDLE;
      scrHigh_r <= 1'b0;
      scrPend_r <= `DTSA_SCROLL_RST;
      tearEnable_r <= 1'b0;
      tearMode_r <= `DTSA_TEAR_MODE_RST;
      idleMode <= 1'b0;
      sleepIn <= 1'b1;
    end
    else
    begin
      state_r <= state_nxt;
      if (isCmdByte)
      begin
        scrHigh_r <= 1'b0;
        if (isCmd(datSync2_r, `DTSA_CMD_TEAR_OFF))
          tearEnable_r <= 1'b0;
        if (isCmd(datSync2_r, `DTSA_CMD_IDLE_OFF))
          idleMode <= 1'b0;
        if (isCmd(datSync2_r, `DTSA_CMD_IDLE_ON))
          idleMode <= 1'b1;
        if (isCmd(datSync2_r, `DTSA_CMD_SLPIN))
          sleepIn <= 1'b1;
        if (isCmd(datSync2_r, `DTSA_CMD_SLPOUT))
          sleepIn <= 1'b0;
      end
      else if (isParByte)
      begin
        case (state_r)
          ST_TEAR:
          begin
            // Re-issue while on leaves enable and mode unchanged
            if (!tearEnable_r)
            begin
              tearEnable_r <= 1'b1;
              tearMode_r <= datSync2_r[0];
            end
          end
          ST_ACC:
            access_r <= datSync2_r & `DTSA_ACCESS_MASK;
          ST_SCR:
          begin
            if (!scrHigh_r)
            begin
              scrHiByte_r <= datSync2_r;
              scrHigh_r <= 1'b1;
            end
            else
            begin
              scrPend_r <= {scrHiByte_r, datSync2_r};
              scrHigh_r <= 1'b0;
            end
          end
          default:
            scrHigh_r <= 1'b0;
        endcase
      end
    end
  end

  // ==========================================================
  // Access control fields decoded straight from the stored byte
  always @(posedge core_clk)
  begin
    if (!resetn)
    begin
      pageOrderBit <= 1'b0;
      columnOrderBit <= 1'b0;
      pageColumnSwapBit <= 1'b0;
      lineRefreshOrderBit <= 1'b0;
      colourOrderBit <= 1'b0;
      latchOrderBit <= 1'b0;
    end
    else
    begin
      pageOrderBit <= access_r[`DTSA_BIT_PAGE];
      columnOrderBit <= access_r[`DTSA_BIT_COL];
      pageColumnSwapBit <= access_r[`DTSA_BIT_SWAP];
      lineRefreshOrderBit <= access_r[`DTSA_BIT_LINE];
      colourOrderBit <= access_r[`DTSA_BIT_BGR];
      latchOrderBit <= access_r[`DTSA_BIT_LATCH];
    end
  end

  // ==========================================================
  // Scroll pointer; shadow loads only at frame start to avoid tearing
  always @(posedge core_clk)
  begin
    if (!resetn)
      scrollStartPointer <= `DTSA_SCROLL_RST;
    else if (frameStart)
      scrollStartPointer <= scrPend_r;
  end

  // Lines past the top fixed area map from the pointer onward, wrapping
  // at the panel height; the host keeps the pointer in the scroll area
  assign offsetLine = scrollStartPointer + (panelLine - topFixedHeight);
  assign wrapLine = (offsetLine >= `DTSA_PANEL_LINES) ?
                    offsetLine - `DTSA_PANEL_LINES : offsetLine;

  always @(posedge core_clk)
  begin
    if (!resetn)
      memLine <= 16'h0000;
    else if (panelLine < topFixedHeight)
      memLine <= panelLine;
    else
      memLine <= wrapLine;
  end

  // ==========================================================
  // Colour reduction; idle keeps only each component's top bit
  always @(posedge core_clk)
  begin
    if (!resetn)
      pixelOut <= 18'h0_0000;
    else if (idleMode)
      pixelOut <= {{6{pixelIn[17]}}, {6{pixelIn[11]}},
                   {6{pixelIn[5]}}};
    else
      pixelOut <= pixelIn;
  end

  // ==========================================================
  // Tearing pin; line refresh order is deliberately not wired in
  dtsa_tear_gen u_tear
  (
    .core_clk(core_clk),
    .resetn(resetn),
    .tearEnable(tearEnable_r),
    .tearMode(tearMode_r),
    .sleepIn(sleepIn),
    .vBlank(vBlank),
    .hBlank(hBlank),
    .tearSyncPin(tearSyncPin)
  );
endmodule

// ### verif/dtsa_host_model.sv
// Purpose: Host processor model writing bytes on the command interface
// Assumes: Called from the bench; pins move at falling edges only
// Notes: Released data bus shows the inverse of the last byte
module dtsa_host_model
(
  input wire core_clk,
  output logic writeStrobe,
  output logic dataCommandSelect,
  output logic [7:0] hostData
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Idle pins: strobe high, bus holds no valid byte
  initial
  begin
    writeStrobe = 1'b1;
    dataCommandSelect = 1'b1;
    hostData = 8'h00;
  end
  // One byte; strobe low and high four cycles each, so the core's
  // synchronisers see every edge
  task put(input logic dc, input logic [7:0] d);
    @(negedge core_clk);
    dataCommandSelect = dc;
    hostData = d;
    writeStrobe = 1'b0;
    repeat (4) @(negedge core_clk);
    writeStrobe = 1'b1;
    repeat (4) @(negedge core_clk);
    hostData = ~d;
  endtask
endmodule

// ### verif/dtsa_cmd_core_asserts.sv
// Purpose: Port-level checks for the command core
// Assumes: One clock domain; sees only top ports
// Notes: Line map checked outside the scroll area or with no fixed top
module dtsa_cmd_core_asserts
#(
  parameter PTR_W = 16
)
(
  input wire core_clk,
  input wire resetn,
  input wire writeStrobe,
  input wire vBlank,
  input wire hBlank,
  input wire frameStart,
  input wire [PTR_W-1:0] topFixedHeight,
  input wire [PTR_W-1:0] panelLine,
  input wire [17:0] pixelIn,
  input wire tearSyncPin,
  input wire pageOrderBit,
  input wire columnOrderBit,
  input wire pageColumnSwapBit,
  input wire lineRefreshOrderBit,
  input wire colourOrderBit,
  input wire latchOrderBit,
  input wire [PTR_W-1:0] scrollStartPointer,
  input wire [PTR_W-1:0] memLine,
  input wire idleMode,
  input wire sleepIn,
  input wire [17:0] pixelOut
);
  timeunit 1ns;
  timeprecision 1ps;
  logic prevStrobe_r;
  logic [3:0] quietCnt_r;
  logic [PTR_W:0] sumLine;
  logic [PTR_W-1:0] expLine;
  logic lineOk;
  logic [17:0] msbPix;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // ==========================================================
  // Cycles since the raw strobe rose; a byte lands well inside 8
  always @(posedge core_clk)
  begin
    prevStrobe_r <= writeStrobe;
    if (!resetn || (writeStrobe && !prevStrobe_r))
      quietCnt_r <= 4'h0;
    else if (quietCnt_r != 4'hF)
      quietCnt_r <= quietCnt_r + 4'h1;
  end
  // Expected frame line and idle pixel, wrap at 320 lines
  assign sumLine = {1'b0, panelLine} + {1'b0, scrollStartPointer};
  assign lineOk = (topFixedHeight == 0) || (panelLine < topFixedHeight);
  assign expLine = (panelLine < topFixedHeight) ? panelLine :
    (sumLine >= 17'h0_0140) ? PTR_W'(sumLine - 17'h0_0140) : PTR_W'(sumLine);
  assign msbPix = {{6{pixelIn[17]}}, {6{pixelIn[11]}}, {6{pixelIn[5]}}};
  sequence asleep_s;
    sleepIn ##1 sleepIn;
  endsequence
  sequence idle_s;
    $past(resetn) && idleMode && $past(idleMode);
  endsequence
  sequence full_s;
    $past(resetn) && !idleMode && !$past(idleMode);
  endsequence
  // ==========================================================
  tear_sleep_low_a: assert property (asleep_s |-> !tearSyncPin)
    else $error("tear pin high during sleep");
  tear_needs_blank_a: assert property (
    !vBlank && !hBlank |=> !tearSyncPin)
    else $error("tear pin high outside blanking");
  tear_rise_cause_a: assert property (
    $rose(tearSyncPin) |-> $past(vBlank || hBlank))
    else $error("tear pin rose without blanking");
  access_quiet_a: assert property (quietCnt_r > 4'h8 |-> $stable({pageOrderBit,
    columnOrderBit, pageColumnSwapBit, lineRefreshOrderBit, colourOrderBit,
    latchOrderBit, idleMode, sleepIn})) else $error("state moved with no byte");
  scroll_at_frame_a: assert property (
    !$stable(scrollStartPointer) |-> $past(frameStart))
    else $error("scroll pointer moved mid frame");
  idle_pixel_a: assert property (idle_s |-> pixelOut == $past(msbPix))
    else $error("idle pixel not from component msbs");
  full_pixel_a: assert property (full_s |-> pixelOut == $past(pixelIn))
    else $error("full colour pixel altered");
  line_map_a: assert property ($past(resetn) && $past(lineOk) &&
    !$past(lineRefreshOrderBit) && $stable(scrollStartPointer)
    |-> memLine == $past(expLine)) else $error("frame line map wrong");
endmodule
bind dtsa_cmd_core dtsa_cmd_core_asserts #(.PTR_W(PTR_W)) chk (
  .core_clk(core_clk), .resetn(resetn), .writeStrobe(writeStrobe),
  .vBlank(vBlank), .hBlank(hBlank), .frameStart(frameStart),
  .topFixedHeight(topFixedHeight), .panelLine(panelLine),
  .pixelIn(pixelIn), .tearSyncPin(tearSyncPin),
  .pageOrderBit(pageOrderBit), .columnOrderBit(columnOrderBit),
  .pageColumnSwapBit(pageColumnSwapBit),
  .lineRefreshOrderBit(lineRefreshOrderBit),
  .colourOrderBit(colourOrderBit), .latchOrderBit(latchOrderBit),
  .scrollStartPointer(scrollStartPointer), .memLine(memLine),
  .idleMode(idleMode), .sleepIn(sleepIn), .pixelOut(pixelOut));

// ### verif/dtsa_cmd_core_tb_top.sv
// Purpose: Self-checking bench for the command core
// Assumes: Host model drives the strobe pins; bench drives panel side
// Notes: A byte settles about four cycles after the strobe rises
module dtsa_cmd_core_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [7:0] d; logic [5:0] e;} dtsa_row_t;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic vBlank = 1'b0;
  logic hBlank = 1'b0;
  logic frameStart = 1'b0;
  logic [15:0] topFixedHeight = 16'h0000;
  logic [15:0] panelLine = 16'h0000;
  logic [17:0] pixelIn = 18'h0_0000;
  wire writeStrobe, dataCommandSelect, tearSyncPin, idleMode, sleepIn;
  wire [7:0] hostData;
  wire [5:0] accessBits;
  wire [15:0] scrollStartPointer, memLine;
  wire [17:0] pixelOut;
  int badCount = 0;
  int checksDone = 0;
  dtsa_row_t rows [8] = '{'{8'h80, 6'h20}, '{8'h40, 6'h10},
    '{8'h20, 6'h08}, '{8'h10, 6'h04}, '{8'h08, 6'h02},
    '{8'h04, 6'h01}, '{8'h03, 6'h00}, '{8'hFF, 6'h3F}};
  always #5 core_clk = ~core_clk;
  dtsa_host_model host (.core_clk(core_clk), .writeStrobe(writeStrobe),
    .dataCommandSelect(dataCommandSelect), .hostData(hostData));
  dtsa_cmd_core DUT (.core_clk(core_clk), .resetn(resetn),
    .writeStrobe(writeStrobe), .dataCommandSelect(dataCommandSelect),
    .hostData(hostData), .vBlank(vBlank), .hBlank(hBlank),
    .frameStart(frameStart), .topFixedHeight(topFixedHeight),
    .panelLine(panelLine), .pixelIn(pixelIn), .tearSyncPin(tearSyncPin),
    .pageOrderBit(accessBits[5]), .columnOrderBit(accessBits[4]),
    .pageColumnSwapBit(accessBits[3]), .lineRefreshOrderBit(accessBits[2]),
    .colourOrderBit(accessBits[1]), .latchOrderBit(accessBits[0]),
    .scrollStartPointer(scrollStartPointer), .memLine(memLine),
    .idleMode(idleMode), .sleepIn(sleepIn), .pixelOut(pixelOut));
  // ==========================================================
  // Shared helpers
  // Wide enough for the idle flag beside a full pixel
  task chk(input logic [19:0] got, input logic [19:0] exp);
    checksDone++;
    if (got !== exp)
    begin
      badCount++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Byte plus settling time for the synchronisers
  task wr(input logic dc, input logic [7:0] d);
    host.put(dc, d);
    repeat (2) @(negedge core_clk);
  endtask
  task tear(input logic v, input logic h, input logic exp);
    vBlank = v;
    hBlank = h;
    repeat (2) @(negedge core_clk);
    chk(tearSyncPin, exp);
  endtask
  task frame();
    frameStart = 1'b1;
    @(negedge core_clk);
    frameStart = 1'b0;
    repeat (2) @(negedge core_clk);
  endtask
  task endOfTest();
    $display("checks=%0d mismatches=%0d", checksDone, badCount);
    if (badCount == 0 && checksDone > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Watchdog: the sequence needs well under 20 us
  initial
  begin
    #100us;
    badCount++;
    endOfTest();
  end
  // ==========================================================
  // Main sequence
  initial
  begin
    repeat (5) @(negedge core_clk);
    resetn = 1'b1;
    repeat (4) @(negedge core_clk);
    chk({accessBits, idleMode, sleepIn, tearSyncPin}, 18'h0_0002);
    chk(scrollStartPointer, 18'h0_0000);
    wr(1'b0, 8'h11);
    foreach (rows[i])
    begin
      wr(1'b0, 8'h36);
      wr(1'b1, rows[i].d);
      chk(accessBits, rows[i].e);
    end
    // Tearing modes, repeat enable ignored, refresh order change
    wr(1'b0, 8'h35);
    wr(1'b1, 8'h01);
    tear(1'b0, 1'b1, 1'b1);
    tear(1'b1, 1'b0, 1'b1);
    tear(1'b0, 1'b0, 1'b0);
    wr(1'b0, 8'h35);
    wr(1'b1, 8'h00);
    tear(1'b0, 1'b1, 1'b1);
    wr(1'b0, 8'h34);
    tear(1'b0, 1'b1, 1'b0);
    wr(1'b0, 8'h35);
    wr(1'b1, 8'h00);
    tear(1'b0, 1'b1, 1'b0);
    tear(1'b1, 1'b0, 1'b1);
    wr(1'b0, 8'h36);
    wr(1'b1, 8'hA4);
    tear(1'b1, 1'b0, 1'b1);
    wr(1'b0, 8'h10);
    tear(1'b1, 1'b0, 1'b0);
    chk(sleepIn, 18'h0_0001);
    wr(1'b0, 8'h01);
    wr(1'b0, 8'h11);
    tear(1'b1, 1'b0, 1'b0);
    chk(accessBits, 18'h0_0029);
    // Scroll pointer waits for the frame; partial write is dropped
    wr(1'b0, 8'h37);
    wr(1'b1, 8'h01);
    wr(1'b1, 8'h05);
    chk(scrollStartPointer, 18'h0_0000);
    frame();
    chk(scrollStartPointer, 18'h0_0105);
    panelLine = 16'h0064;
    repeat (2) @(negedge core_clk);
    chk(memLine, 18'h0_0029);
    topFixedHeight = 16'h000A;
    panelLine = 16'h0005;
    repeat (2) @(negedge core_clk);
    chk(memLine, 18'h0_0005);
    wr(1'b0, 8'h37);
    wr(1'b1, 8'h00);
    // Idle on, then exit twice
    wr(1'b0, 8'h39);
    frame();
    chk(scrollStartPointer, 18'h0_0105);
    pixelIn = 18'h2_07DF;
    repeat (2) @(negedge core_clk);
    chk({idleMode, pixelOut}, 19'h7_F000);
    wr(1'b0, 8'h38);
    chk({idleMode, pixelOut}, 19'h2_07DF);
    wr(1'b0, 8'h38);
    chk({idleMode, pixelOut}, 19'h2_07DF);
    // Hardware reset mid-run clears access byte and active pointer
    resetn = 1'b0;
    repeat (5) @(negedge core_clk);
    resetn = 1'b1;
    repeat (4) @(negedge core_clk);
    chk({accessBits, idleMode, sleepIn, tearSyncPin}, 18'h0_0002);
    chk(scrollStartPointer, 18'h0_0000);
    endOfTest();
  end
endmodule
